// ---- design/nvmcs_pkg.sv ----
// Package of offsets, field positions, codes and timing for the command sequencer
package nvmcs_pkg;

  // Register offsets
  localparam logic [3:0] OFS_CMD_CTRL   = 4'h0;
  localparam logic [3:0] OFS_LOCK_CTRL  = 4'h1;
  localparam logic [3:0] OFS_OP_STATUS  = 4'h2;
  localparam logic [3:0] OFS_INT_EN     = 4'h3;
  localparam logic [3:0] OFS_INT_FLAG   = 4'h4;
  localparam logic [3:0] OFS_FUSE_DATA_L = 4'h6;
  localparam logic [3:0] OFS_FUSE_DATA_H = 4'h7;
  localparam logic [3:0] OFS_TGT_ADDR_L = 4'h8;
  localparam logic [3:0] OFS_TGT_ADDR_H = 4'h9;

  // Field positions
  localparam int BIT_APP_CODE_WP   = 0;
  localparam int BIT_BOOT_LOCK     = 1;
  localparam int BIT_FLASH_BUSY    = 0;
  localparam int BIT_EEPROM_BUSY   = 1;
  localparam int BIT_WRITE_FAULT   = 2;
  localparam int BIT_EEPROM_READY  = 0;

  // Values after reset
  localparam logic [2:0]  RST_CMD  = 3'h0;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0]  RST_BYTE = 8'h00;

  // Command codes
  typedef enum logic [2:0] {
    CMD_NONE        = 3'b000,
    CMD_PAGE_WRITE  = 3'b001,
    CMD_PAGE_ERASE  = 3'b010,
    CMD_ERASE_WRITE = 3'b011,
    CMD_BUF_CLEAR   = 3'b100,
    CMD_FULL_ERASE  = 3'b101,
    CMD_EEPROM_WIPE = 3'b110,
    CMD_FUSE_PROG   = 3'b111
  } nvmcs_cmd_e;

  // Section codes of a page buffer load
  localparam logic [1:0] SECT_BOOT     = 2'h0;
  localparam logic [1:0] SECT_APP_CODE = 2'h1;
  localparam logic [1:0] SECT_APP_DATA = 2'h2;
  localparam logic [1:0] SECT_EEPROM   = 2'h3;

  // Buffer clear halt, CPU cycles
  localparam logic [2:0] BUF_CLEAR_CYCLES = 3'd7;

endpackage

// ---- design/nvmcs_page_buffer.sv ----
// Shared page buffer with written-byte marks and AND merge
module nvmcs_page_buffer #(
  parameter int PAGE_BYTES = 64,
  parameter int IDX_W      = 6
) (
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_resetn,
  input  wire logic                    i_wr,
  input  wire logic [IDX_W-1:0]        i_idx,
  input  wire logic [7:0]              i_data,
  input  wire logic                    i_clear,
  output logic      [8*PAGE_BYTES-1:0] o_data,
  output logic      [PAGE_BYTES-1:0]   o_mask,
  output logic                         o_any
);
  import nvmcs_pkg::*;

  logic [7:0]            mem_r   [PAGE_BYTES];
  logic [7:0]            mem_nxt [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] mask_r;
  logic [PAGE_BYTES-1:0] mask_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Per byte: clear to all ones, else AND new data in and mark the byte
  genvar g;
  generate
    for (g = 0; g < PAGE_BYTES; g++)
    begin : g_byte
      always_comb
      begin
        mem_nxt[g]  = mem_r[g];
        mask_nxt[g] = mask_r[g];
        if (i_clear)
        begin
          mem_nxt[g]  = 8'hFF;
          mask_nxt[g] = 1'b0;
        end
        else if (i_wr && (i_idx == IDX_W'(g)))
        begin
          mem_nxt[g]  = mem_r[g] & i_data;
          mask_nxt[g] = 1'b1;
        end
      end

      always_ff @(posedge i_sys_clk or negedge i_resetn)
      begin
        if (!i_resetn)
        begin
          mem_r[g]  <= 8'hFF;
          mask_r[g] <= 1'b0;
        end
        else
        begin
          mem_r[g]  <= mem_nxt[g];
          mask_r[g] <= mask_nxt[g];
        end
      end

      assign o_data[8*g +: 8] = mem_r[g];
    end
  endgenerate

  assign o_mask = mask_r;
  assign o_any  = |mask_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  buf_clear_ones_a: assert property (i_clear |=> (&o_data) && !o_any)
    else $error("page buffer not all ones after clear");
  byte_mark_a: assert property ((i_wr && !i_clear) |=> o_mask[$past(i_idx)])
    else $error("written byte not marked");

endmodule

// ---- design/nvmcs_sequencer.sv ----
// Nonvolatile controller command sequencer with register file
import nvmcs_pkg::*;

module nvmcs_sequencer #(
  parameter int PAGE_BYTES = 64,
  parameter int IDX_W      = 6
) (
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_resetn,
  input  wire logic [3:0]              i_io_addr,
  input  wire logic                    i_io_wr,
  input  wire logic [7:0]              i_io_wdata,
  input  wire logic                    i_spm_unlock,
  input  wire logic                    i_dbg_access,
  input  wire logic                    i_exec_in_boot,
  input  wire logic                    i_pb_wr,
  input  wire logic [15:0]             i_pb_addr,
  input  wire logic [7:0]              i_pb_data,
  input  wire logic [1:0]              i_pb_section,
  input  wire logic                    i_eeprom_keep_fuse,
  input  wire logic                    i_arr_done,
  input  wire logic                    i_idle_sleep,
  input  wire logic                    i_wake,
  output logic      [7:0]              o_io_rdata,
  output logic                         o_arr_start,
  output nvmcs_pkg::nvmcs_cmd_e        o_arr_op,
  output logic                         o_arr_eeprom,
  output logic                         o_arr_keep_ee,
  output logic      [15:0]             o_arr_addr,
  output logic      [15:0]             o_fuse_data,
  output logic      [8*PAGE_BYTES-1:0] o_pb_data,
  output logic      [PAGE_BYTES-1:0]   o_pb_mask,
  output logic                         o_cpu_halt,
  output logic                         o_irq,
  output logic                         o_idle_wake,
  output logic                         o_stay_awake,
  output logic                         o_boot_lock
);
  import nvmcs_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CLEAR = 3'b001,
    ST_ERASE = 3'b010,
    ST_WRITE = 3'b011,
    ST_CHIP  = 3'b100,
    ST_WIPE  = 3'b101,
    ST_FUSE  = 3'b110
  } nvmcs_state_e;

  nvmcs_state_e state_r, state_nxt;
  nvmcs_cmd_e   cmd_r, cmd_nxt, op_r, op_nxt;
  logic [2:0]   cnt_r, cnt_nxt;
  logic         erase_write_cmd_r, erase_write_cmd_nxt, ee_r, ee_nxt, start_r, start_nxt;
  logic         halt_r, halt_nxt, flash_busy_flag_r, flash_busy_flag_nxt, eeprom_busy_flag_r, eeprom_busy_flag_nxt;
  logic         fault_r, fault_nxt, keep_r, keep_nxt;
  logic         app_code_write_protect_r, app_code_write_protect_nxt, block_r, block_nxt;
  logic         inten_r, inten_nxt, flag_r, flag_nxt, irq_r, irq_nxt;
  logic         wake_r, wake_nxt, awake_r, awake_nxt;
  logic [15:0]  addr_r, addr_nxt, data_r, data_nxt;
  logic [1:0]   sect_r, sect_nxt;
  logic         mix_r, mix_nxt;
  logic [7:0]   rdata_r, rdata_nxt;
  logic         pb_clr, pb_any, cmd_wr, cmd_ok, prot;
  nvmcs_cmd_e   cmd_in;

  ////////////////////////////////////////////////////////////////////////////
  // Page buffer
  nvmcs_page_buffer #(
    .PAGE_BYTES (PAGE_BYTES),
    .IDX_W      (IDX_W)
  ) u_pbuf (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_wr      (i_pb_wr),
    .i_idx     (i_pb_addr[IDX_W-1:0]),
    .i_data    (i_pb_data),
    .i_clear   (pb_clr),
    .o_data    (o_pb_data),
    .o_mask    (o_pb_mask),
    .o_any     (pb_any)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command decode and sequencing
  assign cmd_wr = i_io_wr && (i_io_addr == OFS_CMD_CTRL);
  assign cmd_ok = cmd_wr && (i_spm_unlock || i_dbg_access);
  assign cmd_in = nvmcs_cmd_e'(i_io_wdata[2:0]);
  assign prot   = (mix_r || ((sect_r == SECT_BOOT) && !i_dbg_access) ||
                   ((sect_r == SECT_APP_CODE) && app_code_write_protect_r));

  always_comb
  begin
    state_nxt = state_r;
    cmd_nxt   = cmd_r;
    op_nxt    = op_r;
    cnt_nxt   = cnt_r;
    erase_write_cmd_nxt  = erase_write_cmd_r;
    ee_nxt    = ee_r;
    start_nxt = 1'b0;
    fault_nxt = fault_r;
    keep_nxt  = keep_r;
    pb_clr    = i_wake;
    case (state_r)
      ST_IDLE:
      begin
        if (cmd_ok)
        begin
          cmd_nxt = cmd_in;
          case (cmd_in)
            CMD_PAGE_WRITE, CMD_PAGE_ERASE, CMD_ERASE_WRITE:
            begin
              if ((cmd_in != CMD_PAGE_WRITE) && !pb_any)
                cmd_nxt = CMD_NONE;
              else if (prot)
              begin
                fault_nxt = 1'b1;
                pb_clr    = 1'b1;
                cmd_nxt   = CMD_NONE;
              end
              else
              begin
                fault_nxt = 1'b0;
                ee_nxt    = (sect_r == SECT_EEPROM);
                erase_write_cmd_nxt  = (cmd_in == CMD_ERASE_WRITE);
                state_nxt = (cmd_in == CMD_PAGE_WRITE) ? ST_WRITE : ST_ERASE;
                op_nxt    = (cmd_in == CMD_PAGE_WRITE) ? CMD_PAGE_WRITE
                                                       : CMD_PAGE_ERASE;
                start_nxt = 1'b1;
              end
            end
            CMD_BUF_CLEAR:
            begin
              pb_clr    = 1'b1;
              cnt_nxt   = BUF_CLEAR_CYCLES;
              state_nxt = ST_CLEAR;
            end
            CMD_FULL_ERASE:
            begin
              fault_nxt = 1'b0;
              keep_nxt  = i_eeprom_keep_fuse;
              op_nxt    = CMD_FULL_ERASE;
              start_nxt = 1'b1;
              state_nxt = ST_CHIP;
            end
            CMD_EEPROM_WIPE:
            begin
              ee_nxt    = 1'b1;
              op_nxt    = CMD_EEPROM_WIPE;
              start_nxt = 1'b1;
              state_nxt = ST_WIPE;
            end
            CMD_FUSE_PROG:
            begin
              if (i_dbg_access)
              begin
                ee_nxt    = 1'b0;
                op_nxt    = CMD_FUSE_PROG;
                start_nxt = 1'b1;
                state_nxt = ST_FUSE;
              end
              else
                cmd_nxt = cmd_r;
            end
            default: cmd_nxt = CMD_NONE;
          endcase
        end
      end
      ST_CLEAR:
      begin
        cnt_nxt = cnt_r - 3'd1;
        if (cnt_r == 3'd1)
        begin
          state_nxt = ST_IDLE;
          cmd_nxt   = CMD_NONE;
        end
      end
      ST_ERASE:
      begin
        if (i_arr_done)
        begin
          if (erase_write_cmd_r)
          begin
            state_nxt = ST_WRITE;
            op_nxt    = CMD_PAGE_WRITE;
            start_nxt = 1'b1;
          end
          else
          begin
            pb_clr    = 1'b1;
            state_nxt = ST_IDLE;
            cmd_nxt   = CMD_NONE;
          end
        end
      end
      default:
      begin
        if (i_arr_done)
        begin
          pb_clr    = pb_clr || (state_r == ST_WRITE);
          state_nxt = ST_IDLE;
          cmd_nxt   = CMD_NONE;
          erase_write_cmd_nxt  = 1'b0;
        end
      end
    endcase
    // Flash work and full wipes halt the CPU; EEPROM page work does not
    halt_nxt   = (state_nxt == ST_CLEAR) || (state_nxt == ST_CHIP) ||
                 (state_nxt == ST_WIPE) || (state_nxt == ST_FUSE) ||
                 (((state_nxt == ST_ERASE) || (state_nxt == ST_WRITE)) && !ee_nxt);
    flash_busy_flag_nxt  = (state_nxt == ST_CHIP) || (state_nxt == ST_FUSE) ||
                 (((state_nxt == ST_ERASE) || (state_nxt == ST_WRITE)) && !ee_nxt);
    eeprom_busy_flag_nxt = (state_nxt == ST_WIPE) || ((state_nxt == ST_CHIP) && !keep_nxt) ||
                 (((state_nxt == ST_ERASE) || (state_nxt == ST_WRITE)) && ee_nxt);
    awake_nxt  = (state_nxt != ST_IDLE);
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_r  <= ST_IDLE;
      cmd_r    <= CMD_NONE;
      op_r     <= CMD_NONE;
      cnt_r    <= RST_CMD;
      erase_write_cmd_r   <= 1'b0;
      ee_r     <= 1'b0;
      start_r  <= 1'b0;
      halt_r   <= 1'b0;
      flash_busy_flag_r  <= 1'b0;
      eeprom_busy_flag_r <= 1'b0;
      fault_r  <= 1'b0;
      keep_r   <= 1'b0;
      awake_r  <= 1'b0;
    end
    else
    begin
      state_r  <= state_nxt;
      cmd_r    <= cmd_nxt;
      op_r     <= op_nxt;
      cnt_r    <= cnt_nxt;
      erase_write_cmd_r   <= erase_write_cmd_nxt;
      ee_r     <= ee_nxt;
      start_r  <= start_nxt;
      halt_r   <= halt_nxt;
      flash_busy_flag_r  <= flash_busy_flag_nxt;
      eeprom_busy_flag_r <= eeprom_busy_flag_nxt;
      fault_r  <= fault_nxt;
      keep_r   <= keep_nxt;
      awake_r  <= awake_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file, buffer section tracking, interrupt
  always_comb
  begin
    app_code_write_protect_nxt = app_code_write_protect_r;
    block_nxt = block_r;
    inten_nxt = inten_r;
    data_nxt  = data_r;
    addr_nxt  = addr_r;
    flag_nxt  = flag_r;
    if (i_io_wr)
    begin
      if (i_io_addr == OFS_LOCK_CTRL)
      begin
        app_code_write_protect_nxt = app_code_write_protect_r | i_io_wdata[BIT_APP_CODE_WP];
        block_nxt = block_r | (i_io_wdata[BIT_BOOT_LOCK] & i_exec_in_boot);
      end
      else if (i_io_addr == OFS_INT_EN)
        inten_nxt = i_io_wdata[BIT_EEPROM_READY];
      else if (i_io_addr == OFS_INT_FLAG)
        flag_nxt = flag_r & ~i_io_wdata[BIT_EEPROM_READY];
      else if (i_io_addr == OFS_FUSE_DATA_L)
        data_nxt[7:0] = i_io_wdata;
      else if (i_io_addr == OFS_FUSE_DATA_H)
        data_nxt[15:8] = i_io_wdata;
      else if (i_io_addr == OFS_TGT_ADDR_L)
        addr_nxt[7:0] = i_io_wdata;
      else if (i_io_addr == OFS_TGT_ADDR_H)
        addr_nxt[15:8] = i_io_wdata;
    end
    if (i_pb_wr)
      addr_nxt = i_pb_addr;
    if (!eeprom_busy_flag_r)
      flag_nxt = 1'b1;
    irq_nxt  = inten_nxt && flag_nxt;
    wake_nxt = irq_nxt && i_idle_sleep;
    sect_nxt = sect_r;
    mix_nxt  = mix_r;
    if (pb_clr)
    begin
      sect_nxt = SECT_BOOT;
      mix_nxt  = 1'b0;
    end
    else if (i_pb_wr && !pb_any)
      sect_nxt = i_pb_section;
    else if (i_pb_wr && (i_pb_section != sect_r))
      mix_nxt = 1'b1;
    rdata_nxt = RST_BYTE;
    if (i_io_addr == OFS_CMD_CTRL)
      rdata_nxt = {5'h00, cmd_r};
    else if (i_io_addr == OFS_LOCK_CTRL)
      rdata_nxt = {6'h00, block_r, app_code_write_protect_r};
    else if (i_io_addr == OFS_OP_STATUS)
      rdata_nxt = {5'h00, fault_r, eeprom_busy_flag_r, flash_busy_flag_r};
    else if (i_io_addr == OFS_INT_EN)
      rdata_nxt = {7'h00, inten_r};
    else if (i_io_addr == OFS_INT_FLAG)
      rdata_nxt = {7'h00, flag_r};
    else if (i_io_addr == OFS_FUSE_DATA_L)
      rdata_nxt = data_r[7:0];
    else if (i_io_addr == OFS_FUSE_DATA_H)
      rdata_nxt = data_r[15:8];
    else if (i_io_addr == OFS_TGT_ADDR_L)
      rdata_nxt = addr_r[7:0];
    else if (i_io_addr == OFS_TGT_ADDR_H)
      rdata_nxt = addr_r[15:8];
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      app_code_write_protect_r <= 1'b0;
      block_r <= 1'b0;
      inten_r <= 1'b0;
      flag_r  <= 1'b0;
      irq_r   <= 1'b0;
      wake_r  <= 1'b0;
      data_r  <= RST_WORD;
      addr_r  <= RST_WORD;
      sect_r  <= SECT_BOOT;
      mix_r   <= 1'b0;
      rdata_r <= RST_BYTE;
    end
    else
    begin
      app_code_write_protect_r <= app_code_write_protect_nxt;
      block_r <= block_nxt;
      inten_r <= inten_nxt;
      flag_r  <= flag_nxt;
      irq_r   <= irq_nxt;
      wake_r  <= wake_nxt;
      data_r  <= data_nxt;
      addr_r  <= addr_nxt;
      sect_r  <= sect_nxt;
      mix_r   <= mix_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign o_io_rdata    = rdata_r;
  assign o_arr_start   = start_r;
  assign o_arr_op      = op_r;
  assign o_arr_eeprom  = ee_r;
  assign o_arr_keep_ee = keep_r;
  assign o_arr_addr    = addr_r;
  assign o_fuse_data   = data_r;
  assign o_cpu_halt    = halt_r;
  assign o_irq         = irq_r;
  assign o_idle_wake   = wake_r;
  assign o_stay_awake  = awake_r;
  assign o_boot_lock   = block_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_clear_go;
    (state_r == ST_IDLE) && cmd_ok && (cmd_in == CMD_BUF_CLEAR);
  endsequence
  sequence s_halt_seven;
    o_cpu_halt [*7] ##1 !o_cpu_halt;
  endsequence

  buf_clear_halt_a: assert property (s_clear_go |=> s_halt_seven)
    else $error("buffer clear halt not seven cycles");
  ee_page_run_a: assert property (((state_r == ST_ERASE) || (state_r == ST_WRITE)) && ee_r
                                  |-> !o_cpu_halt && eeprom_busy_flag_r && !flash_busy_flag_r)
    else $error("CPU halted during EEPROM page work");
  flash_page_halt_a: assert property (((state_r == ST_ERASE) || (state_r == ST_WRITE)) && !ee_r
                                      |-> o_cpu_halt && flash_busy_flag_r)
    else $error("CPU running during flash page work");
  cmd_locked_a: assert property ((state_r == ST_IDLE) && cmd_wr && !i_spm_unlock &&
                                 !i_dbg_access |=> $stable(cmd_r) && $stable(state_r))
    else $error("command taken without unlock");
  empty_erase_a: assert property ((state_r == ST_IDLE) && cmd_ok && !pb_any &&
                                  (cmd_in == CMD_PAGE_ERASE)
                                  |=> (state_r == ST_IDLE) && $stable(fault_r))
    else $error("erase ran on empty buffer");
  erase_write_cmd_phase_a: assert property ((state_r == ST_ERASE) && erase_write_cmd_r && i_arr_done && !i_wake
                                 |=> (state_r == ST_WRITE) && o_arr_start && pb_any)
    else $error("erase-write second phase wrong");
  write_clear_a: assert property ((state_r == ST_WRITE) && i_arr_done |=> !pb_any)
    else $error("buffer not cleared after write");
  fuse_cpu_a: assert property ((state_r == ST_IDLE) && cmd_wr && !i_dbg_access &&
                               (cmd_in == CMD_FUSE_PROG) |=> state_r != ST_FUSE)
    else $error("fuse write from CPU");
  ready_flag_a: assert property (!eeprom_busy_flag_r |=> flag_r)
    else $error("ready flag low while EEPROM idle");
  irq_cause_a: assert property (o_irq |-> inten_r && flag_r)
    else $error("interrupt without enabled flag");
  stay_awake_a: assert property ((state_r != ST_IDLE) |-> o_stay_awake)
    else $error("sleep allowed during write");
  idle_wake_a: assert property (o_idle_wake |-> $past(i_idle_sleep) && o_irq)
    else $error("wake outside idle sleep");

endmodule

// ---- tb/nvmcs_array_model.sv ----
// Array model that answers every start with a done pulse after a set delay
module nvmcs_array_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_start,
  input  wire logic [3:0] i_delay,
  output logic            o_done
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Busy countdown, reset aborts
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      cnt <= 0;
    else if (i_start)
      cnt <= int'(i_delay) + 1;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
  assign o_done = (cnt == 1);
endmodule

// ---- tb/nvm_command_sequencer_test.sv ----
// Self-checking bench for the command sequencer
module nvm_command_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  import nvmcs_pkg::*;
  logic clk = 0, rstn = 0, io_wr = 0, unlock = 0, dbg = 0, pb_wr = 0;
  logic keep = 0, wake = 0, sleep = 0, boot = 0, ee, start, ee_t, keep_ee, halt, irq, iwake;
  logic awake, done, blk;
  logic [3:0] addr = 0, dly = 4'h8;
  logic [7:0] wdata = 0, pbd = 0, b1, b2, rdata;
  logic [15:0] pba = 0, aaddr, fdata;
  logic [1:0] sect = 0, s;
  logic [5:0] ix;
  logic [511:0] pdata;
  logic [63:0] pmask;
  logic [31:0] seed = 32'h03AB;
  nvmcs_cmd_e op;
  int n_fail = 0, samples_checked = 0, n;
  int pbm [64];

  nvmcs_sequencer i_dut (.i_sys_clk(clk), .i_resetn(rstn), .i_io_addr(addr), .i_io_wr(io_wr),
    .i_io_wdata(wdata), .i_spm_unlock(unlock), .i_dbg_access(dbg), .i_exec_in_boot(boot),
    .i_pb_wr(pb_wr), .i_pb_addr(pba), .i_pb_data(pbd), .i_pb_section(sect),
    .i_eeprom_keep_fuse(keep), .i_arr_done(done), .i_idle_sleep(sleep), .i_wake(wake),
    .o_io_rdata(rdata), .o_arr_start(start), .o_arr_op(op), .o_arr_eeprom(ee_t),
    .o_arr_keep_ee(keep_ee), .o_arr_addr(aaddr), .o_fuse_data(fdata), .o_pb_data(pdata),
    .o_pb_mask(pmask), .o_cpu_halt(halt), .o_irq(irq), .o_idle_wake(iwake),
    .o_stay_awake(awake), .o_boot_lock(blk));
  nvmcs_array_model i_arr (.i_sys_clk(clk), .i_resetn(rstn), .i_start(start), .i_delay(dly),
    .o_done(done));

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    io_wr = 1'b1;
    @(negedge clk);
    io_wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    chk(rdata, e);
  endtask
  task automatic st(input logic [1:0] sc, input logic [7:0] d);
    @(negedge clk);
    pb_wr = 1'b1;
    sect = sc;
    pbd = d;
    pba = {10'h000, ix};
    pbm[ix] = pbm[ix] & int'(d);
    @(negedge clk);
    pb_wr = 1'b0;
  endtask
  task automatic pb_model_clear();
    for (int i = 0; i < 64; i++)
      pbm[i] = 255;
  endtask
  task automatic chk_pb();
    for (int i = 0; i < 64; i++)
      chk(pdata[8*i +: 8], pbm[i]);
  endtask
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial forever #5 clk = ~clk;
  initial
  begin
    #400000;
    n_fail++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    ix = 6'h05;
    pb_model_clear();
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    for (int a = 0; a < 10; a++)
      rd_chk(4'(a), (a == 4) ? 8'h01 : 8'h00);
    chk({31'h0, &pdata}, 1);
    chk_pb();
    wr(OFS_LOCK_CTRL, 8'h02);
    rd_chk(OFS_LOCK_CTRL, 8'h00);
    boot = 1'b1;
    wr(OFS_LOCK_CTRL, 8'h03);
    boot = 1'b0;
    rd_chk(OFS_LOCK_CTRL, 8'h03);
    chk(blk, 1);
    wr(OFS_INT_EN, 8'h01);
    @(negedge clk);
    chk(irq, 1);
    sleep = 1'b1;
    repeat (2) @(negedge clk);
    chk(iwake, 1);
    sleep = 1'b0;
    st(SECT_APP_DATA, 8'h5A);
    chk(aaddr, 16'h0005);
    wr(OFS_CMD_CTRL, 8'h01);
    chk(start, 0);
    unlock = 1'b1;
    wr(OFS_CMD_CTRL, 8'h07);
    chk(start, 0);
    @(negedge clk);
    wake = 1'b1;
    @(negedge clk);
    wake = 1'b0;
    pb_model_clear();
    chk({31'h0, |pmask}, 0);
    chk_pb();
    wr(OFS_CMD_CTRL, 8'h02);
    chk(start, 0);
    st(SECT_APP_CODE, 8'h11);
    st(SECT_APP_DATA, 8'h22);
    wr(OFS_CMD_CTRL, 8'h01);
    chk(start, 0);
    rd_chk(OFS_OP_STATUS, 8'h04);
    st(SECT_APP_CODE, 8'h44);
    wr(OFS_CMD_CTRL, 8'h03);
    chk(start, 0);
    pb_model_clear();
    chk_pb();
    for (int c = 1; c < 8; c++)
      for (int k = 0; k < 2; k++)
      begin
        seed = xorshift(seed);
        s = seed[0] ? SECT_EEPROM : SECT_APP_DATA;
        {b2, b1} = seed[23:8];
        ix = seed[5:0];
        keep = seed[24];
        dly = {1'b1, seed[27:25]};
        dbg = (c == 7);
        if (c < 4)
        begin
          st(s, b1);
          st(s, b2);
          chk(pdata[8*ix +: 8], b1 & b2);
          chk_pb();
          chk(aaddr, {10'h000, ix});
        end
        if (c == 7)
          wr(OFS_FUSE_DATA_L, b2);
        wr(OFS_CMD_CTRL, 8'(c));
        ee = (c < 4) ? (s == SECT_EEPROM) : (c == 6);
        n = 0;
        if (c == 4)
        begin
          while (halt === 1'b1 && n < 20)
          begin
            n++;
            @(negedge clk);
          end
          chk(n, 7);
          chk({31'h0, &pdata}, 1);
          pb_model_clear();
          chk_pb();
        end
        else
        begin
          chk(start, 1);
          chk(op, (c == 3) ? 2 : c);
          chk(halt, (c > 4) || !ee);
          chk(awake, 1);
          if (c != 5)
            chk(ee_t, ee);
          if (c == 5)
            chk(keep_ee, keep);
          if (c == 7)
            chk(fdata[7:0], b2);
          rd_chk(OFS_OP_STATUS, {6'h0, ee || (c == 5 && !keep), !ee});
          if (ee)
          begin
            wr(OFS_INT_FLAG, 8'h01);
            @(negedge clk);
            chk(irq, 0);
          end
          while ((awake === 1'b1 || halt === 1'b1) && n < 60)
          begin
            n++;
            @(negedge clk);
          end
          chk({31'h0, n < 60}, 1);
          chk(op, (c == 3) ? 1 : c);
          repeat (2) @(negedge clk);
          chk(irq, 1);
          if (c < 4)
          begin
            chk({31'h0, &pdata}, 1);
            pb_model_clear();
            chk_pb();
          end
          rd_chk(OFS_OP_STATUS, 8'h00);
        end
        rd_chk(OFS_CMD_CTRL, 8'h00);
      end
    dbg = 1'b0;
    st(SECT_APP_DATA, 8'h3C);
    wr(OFS_CMD_CTRL, 8'h01);
    @(negedge clk);
    rstn = 1'b0;
    @(negedge clk);
    rstn = 1'b1;
    chk(halt, 0);
    chk(awake, 0);
    pb_model_clear();
    chk_pb();
    rd_chk(OFS_OP_STATUS, 8'h00);
    print_verdict();
  end
endmodule
